/* hw/edge_filter.sv */
// sampled two-sample noise filter and valid edge detector for the trigger pin
`timescale 1ns/1ps
module edge_filter
    import timer16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin_in,
    input wire logic [1:0] sample_rate_select,
    input wire logic [3:0] edge_mode_register,
    output logic valid_edge
);
    logic sync1_reg, sync2_reg;
    logic [5:0] div_reg;
    logic samp_a_reg, samp_b_reg, level_reg;
    logic [1:0] edge_sel;
    logic [5:0] div_top;
    logic sample_tick;
    logic filt_next;
    logic rise, fall;

    assign edge_sel = {edge_mode_register[EDGE_SEL_HI_POS], edge_mode_register[EDGE_SEL_LO_POS]};
    assign div_top = (sample_rate_select == SAMPLE_DIV1) ? 6'h00 :
                     (sample_rate_select == SAMPLE_DIV4) ? 6'h03 :
                     (sample_rate_select == SAMPLE_DIV16) ? 6'h0f : 6'h3f;
    assign sample_tick = (div_reg >= div_top);
    // accept a new level only when two consecutive samples agree
    assign filt_next = (samp_a_reg == samp_b_reg) ? samp_b_reg : level_reg;
    assign rise = sample_tick && filt_next && !level_reg;
    assign fall = sample_tick && !filt_next && level_reg;
    assign valid_edge = (edge_sel == EDGE_BOTH) ? (rise | fall) :
                        (edge_sel == EDGE_RISE) ? rise :
                        (edge_sel == EDGE_FALL) ? fall : 1'b0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            div_reg <= SAMPLE_CNT_RESET;
            samp_a_reg <= 1'b0;
            samp_b_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            div_reg <= sample_tick ? SAMPLE_CNT_RESET : div_reg + 6'h01;
            if (sample_tick) begin
                samp_a_reg <= sync2_reg;
                samp_b_reg <= samp_a_reg;
                level_reg <= filt_next;
            end
        end
    end
endmodule : edge_filter

/* hw/timer16_one_shot_pulse.sv */
// 16-bit timer/event counter, one-shot pulse mode with capture and overflow
`timescale 1ns/1ps
// Function
// - counter stays stopped while mode bits are zero; runs on any other value
// - valid edge on trigger pin selectable rising, falling or both
// - valid edge in external one-shot clears and starts the counter
// - output activates at begin compare, deactivates at end compare
// - further trigger edges ignored while an external pulse is in progress
// - first match may be up to one count clock early after start, never late
// - end compare below count: counter wraps through zero before matching
// - edge during begin-register read skips capture, keeps old value
// - edge irq flag is set even when capture is skipped
// - wrap flag set in clear-on-end mode, end=ffff, count ffff to 0000
// - soft trigger bit clears and starts counter when not in external mode, then pulse as
// - counter keeps running after pulse until the mode bits are zero
// - input sampled; edge valid after two equal consecutive samples
module timer16_one_shot_pulse
    import timer16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input timer16_pkg::timer_ctrl_t timer_mode_control,
    input timer16_pkg::compare_pair_t compare_write_data,
    input wire logic compare_end_write,
    input wire logic compare_begin_write,
    input wire logic compare_begin_read,
    input wire logic soft_pulse_trigger,
    input wire logic capture_enable,
    input wire logic [1:0] count_prescale,
    input wire logic [3:0] edge_mode_register,
    input wire logic [1:0] sample_rate_select,
    input wire logic trigger_input_pin,
    input wire logic wrap_flag_clear,
    output logic [15:0] count_register,
    output logic [15:0] compare_end_register,
    output logic [15:0] compare_begin_register,
    output logic pulse_output_pin,
    output logic end_match_irq,
    output logic input_edge_irq,
    output logic input_edge_irq_flag,
    output logic wrap_flag,
    output logic pulse_busy
);
    import timer16_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] count_reg, count_next;
    logic [15:0] end_reg, begin_reg;
    logic [1:0] pre_reg;
    logic out_reg, out_next;
    logic match_irq_reg, edge_irq_reg, edge_flag_reg, wrap_reg;
    pulse_state_t state_reg, state_next;

    logic running, tick, edge_valid, ext_mode, start_shot;
    logic hit_begin, hit_end, clear_on_end, wraps, do_capture;
    logic wrap_set, match_in_shot, begin_load;

    // ------------------------------------------------------------
    // trigger pin filter
    // ------------------------------------------------------------
    edge_filter edge_filter_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(trigger_input_pin),
        .sample_rate_select(sample_rate_select),
        .edge_mode_register(edge_mode_register),
        .valid_edge(edge_valid)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign running = (timer_mode_control.mode_select != MODE_STOP);
    // count tick comes from a free prescaler, so a start lands anywhere in its period
    assign tick = running && (pre_reg == count_prescale);
    assign ext_mode = timer_mode_control.external_trigger;
    // edges during a pulse are dropped; software trigger is not filtered (caller's duty)
    assign start_shot = running && ((soft_pulse_trigger && !ext_mode)
                        || (ext_mode && edge_valid && (state_reg == PULSE_IDLE || state_reg == PULSE_DONE)));
    assign hit_begin = tick && (count_reg == begin_reg);
    assign hit_end = tick && (count_reg == end_reg);
    assign clear_on_end = (timer_mode_control.mode_select == MODE_CLEAR_ON_END);
    // no early wrap: a smaller end value is only met after passing ffff
    assign wraps = tick && (count_reg == CNT_MAX);
    assign count_next = start_shot ? CNT_ZERO :
                        !running ? CNT_ZERO :
                        (hit_end && clear_on_end) ? CNT_ZERO :
                        tick ? count_reg + 16'h0001 : count_reg;
    assign do_capture = capture_enable && edge_valid && running && !compare_begin_read;
    // flag and load decisions as named wires, so the register processes stay plain
    assign wrap_set = clear_on_end && (end_reg == CNT_MAX) && wraps;
    assign match_in_shot = hit_end && ((state_reg == PULSE_HIGH) || clear_on_end);
    assign begin_load = compare_begin_write && !do_capture;

    always_comb begin
        state_next = state_reg;
        out_next = out_reg;
        unique case (state_reg)
            PULSE_IDLE, PULSE_DONE: begin
                out_next = 1'b0;
                if (start_shot) state_next = PULSE_WAIT;
            end
            PULSE_WAIT: begin
                if (hit_begin) begin
                    state_next = PULSE_HIGH;
                    out_next = 1'b1;
                end
            end
            PULSE_HIGH: begin
                if (hit_end) begin
                    state_next = PULSE_DONE;
                    out_next = 1'b0;
                end
            end
        endcase
        if (!running) begin
            state_next = PULSE_IDLE;
            out_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    // the prescaler never stops, which is where the start error of one count clock comes from
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_reg <= PRESCALE_RESET;
        end else begin
            pre_reg <= (pre_reg == count_prescale) ? PRESCALE_RESET : pre_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // pulse sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= PULSE_IDLE;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            out_reg <= out_next;
        end
    end

    // ------------------------------------------------------------
    // compare registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            end_reg <= COMPARE_RESET;
        end else if (compare_end_write) begin
            end_reg <= compare_write_data.compare_end;
        end
    end

    // a capture wins over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            begin_reg <= COMPARE_RESET;
        end else if (do_capture) begin
            begin_reg <= count_reg;
        end else if (begin_load) begin
            begin_reg <= compare_write_data.compare_begin;
        end
    end

    // ------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_irq_reg <= 1'b0;
            edge_irq_reg <= 1'b0;
            edge_flag_reg <= 1'b0;
        end else begin
            match_irq_reg <= match_in_shot;
            edge_irq_reg <= edge_valid;
            // raised on every valid edge, whether or not the capture was taken
            edge_flag_reg <= edge_valid;
        end
    end

    // sticky until cleared; a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrap_reg <= 1'b0;
        end else if (wrap_set) begin
            wrap_reg <= 1'b1;
        end else if (wrap_flag_clear) begin
            wrap_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign count_register = count_reg;
    assign compare_end_register = end_reg;
    assign compare_begin_register = begin_reg;
    assign pulse_output_pin = timer_mode_control.output_enable &
                              (out_reg ^ timer_mode_control.output_active_low);
    assign end_match_irq = match_irq_reg;
    assign input_edge_irq = edge_irq_reg;
    assign input_edge_irq_flag = edge_flag_reg;
    assign wrap_flag = wrap_reg;
    assign pulse_busy = (state_reg == PULSE_WAIT) || (state_reg == PULSE_HIGH);
endmodule : timer16_one_shot_pulse

/* hw/timer16_pkg.sv */
// shared constants and types for the 16-bit one-shot timer
package timer16_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // mode field (three mode-select bits, bits 3..5 of the mode control)
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [2:0] MODE_CLEAR_ON_END = 3'h6;
    localparam logic [2:0] MODE_CLEAR_ON_EDGE = 3'h4;
    // edge select encoding (bits 2 and 3 of the edge mode register)
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int EDGE_SEL_LO_POS = 2;
    localparam int EDGE_SEL_HI_POS = 3;
    // sampling interval choices, in system clocks
    localparam logic [1:0] SAMPLE_DIV1 = 2'h0;
    localparam logic [1:0] SAMPLE_DIV4 = 2'h1;
    localparam logic [1:0] SAMPLE_DIV16 = 2'h2;
    localparam logic [1:0] SAMPLE_DIV64 = 2'h3;
    localparam logic [5:0] SAMPLE_CNT_RESET = 6'h00;
    // count clock prescale, in system clocks
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;

    typedef struct packed {
        logic [2:0] mode_select;
        logic output_enable;
        logic output_active_low;
        logic external_trigger;
    } timer_ctrl_t;

    typedef struct packed {
        logic [15:0] compare_begin;
        logic [15:0] compare_end;
    } compare_pair_t;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b00,
        PULSE_WAIT = 2'b01,
        PULSE_HIGH = 2'b11,
        PULSE_DONE = 2'b10
    } pulse_state_t;
endpackage : timer16_pkg

/* testbench/test_timer16_one_shot_pulse.sv */
// self-checking bench for the one-shot timer
`timescale 1ns/1ps
module test_timer16_one_shot_pulse;
    import timer16_pkg::*;
    logic clk_sys, rst, compare_end_write, compare_begin_write, compare_begin_read, soft_pulse_trigger;
    logic capture_enable, wrap_flag_clear, trigger_input_pin, pulse_output_pin, end_match_irq;
    logic input_edge_irq, input_edge_irq_flag, wrap_flag, pulse_busy;
    logic [1:0] count_prescale, sample_rate_select;
    logic [3:0] edge_mode_register;
    logic [15:0] count_register, compare_end_register, compare_begin_register;
    timer_ctrl_t timer_mode_control;
    compare_pair_t compare_write_data;
    int failures = 0, cmp_count = 0, n, first, seen;
    int lo[7] = '{27, 7, 999, 7, 999, 999, 999};
    timer16_one_shot_pulse timer16_one_shot_pulse_inst (.clk_sys, .rst, .timer_mode_control, .compare_write_data,
        .compare_end_write, .compare_begin_write, .compare_begin_read, .soft_pulse_trigger, .capture_enable,
        .count_prescale, .edge_mode_register, .sample_rate_select, .trigger_input_pin, .wrap_flag_clear,
        .count_register, .compare_end_register, .compare_begin_register, .pulse_output_pin, .end_match_irq,
        .input_edge_irq, .input_edge_irq_flag, .wrap_flag, .pulse_busy);
    trigger_source trigger_source_inst (.clk_sys, .pulse_output_pin, .trigger_input_pin);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : tick
    task automatic set_cmp(input logic [15:0] b, input logic [15:0] e, input logic wb);
        compare_write_data = '{b, e};
        compare_begin_write = wb;
        compare_end_write = 1'b1;
        tick(1);
        compare_begin_write = 1'b0;
        compare_end_write = 1'b0;
    endtask : set_cmp
    task automatic mode(input logic [2:0] m, input logic ext);
        timer_mode_control = '{m, 1'b1, 1'b0, ext};
        tick(1);
    endtask : mode
    task automatic fire;
        soft_pulse_trigger = 1'b1;
        tick(1);
        soft_pulse_trigger = 1'b0;
    endtask : fire
    task automatic wait_irq(input int lim);
        for (n = 0; end_match_irq !== 1'b1 && n < lim; n++) tick(1);
        if (n >= lim) begin
            failures++;
            end_sim();
        end
    endtask : wait_irq
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {compare_end_write, compare_begin_write, compare_begin_read, soft_pulse_trigger} = 4'h0;
        {capture_enable, wrap_flag_clear, count_prescale, sample_rate_select, edge_mode_register} = 10'h000;
        timer_mode_control = '0;
        compare_write_data = '0;
        tick(8);
        rst = 1'b0;
        tick(1);
        check("reset count", count_register, CNT_ZERO);
        check("reset wrap", {15'h0, wrap_flag}, 16'h0);
        fire();
        tick(20);
        check("stopped", count_register, CNT_ZERO);
        set_cmp(16'h0002, 16'h0005, 1'b1);
        for (int m = 1; m < 8; m++) begin
            mode(m[2:0], 1'b0);
            tick(4);
            check("running", {15'h0, count_register != CNT_ZERO}, 16'h1);
        end
        for (int p = 0; p < 4; p++) begin
            count_prescale = p[1:0];
            mode(MODE_STOP, 1'b0);
            mode(MODE_CLEAR_ON_END, 1'b0);
            fire();
            wait_irq(100);
            tick(2);
            check("soft width", trigger_source_inst.width_seen[15:0], 16'(3 * (p + 1)));
        end
        timer_mode_control.output_active_low = 1'b1;
        tick(1);
        check("low-active idle pin", {15'h0, pulse_output_pin}, 16'h1);
        timer_mode_control.output_enable = 1'b0;
        tick(1);
        check("disabled pin", {15'h0, pulse_output_pin}, 16'h0);
        count_prescale = 2'h0;
        set_cmp(16'h0002, 16'h0028, 1'b1);
        // codes 4 to 6 are glitches shorter than one sample period that two-sample filtering must drop
        for (int s = 0; s < 7; s++) begin
            mode(MODE_STOP, 1'b1);
            edge_mode_register = {(s >= 4) ? EDGE_RISE : s[1:0], 2'h0};
            sample_rate_select = (s == 4) ? SAMPLE_DIV4 : (s == 5) ? SAMPLE_DIV16 :
                                 (s == 6) ? SAMPLE_DIV64 : SAMPLE_DIV1;
            mode(MODE_CLEAR_ON_END, 1'b1);
            first = 999;
            for (int i = 0; i < 150; i++) begin
                if (i == 0 || i == ((s == 4) ? 1 : (s == 5) ? 10 : (s == 6) ? 40 : 20))
                    trigger_source_inst.drive(i == 0);
                if (pulse_output_pin === 1'b1 && first == 999) first = i;
                tick(1);
            end
            check("rise time", {15'h0, first >= lo[s] && first <= lo[s] + 4}, 16'h1);
            if (lo[s] != 999) check("ext width", trigger_source_inst.width_seen[15:0], 16'h0026);
        end
        mode(MODE_STOP, 1'b0);
        sample_rate_select = SAMPLE_DIV4;
        edge_mode_register = {EDGE_RISE, 2'h0};
        capture_enable = 1'b1;
        set_cmp(16'h1234, 16'hf000, 1'b1);
        mode(3'h1, 1'b0);
        compare_begin_read = 1'b1;
        trigger_source_inst.drive(1'b1);
        seen = 0;
        repeat (20) begin
            tick(1);
            if (input_edge_irq_flag === 1'b1) seen++;
        end
        check("held", compare_begin_register, 16'h1234);
        check("edge flag", seen[15:0], 16'h0001);
        compare_begin_read = 1'b0;
        trigger_source_inst.drive(1'b0);
        tick(20);
        trigger_source_inst.drive(1'b1);
        tick(20);
        check("captured", {15'h0, compare_begin_register != 16'h1234}, 16'h1);
        mode(MODE_STOP, 1'b0);
        capture_enable = 1'b0;
        set_cmp(16'h0002, 16'h0100, 1'b1);
        mode(MODE_CLEAR_ON_END, 1'b0);
        fire();
        for (n = 0; count_register < 16'h0080 && n < 300; n++) tick(1);
        if (n >= 300) begin
            failures++;
            end_sim();
        end
        set_cmp(16'h0002, 16'h0010, 1'b0);
        seen = 0;
        repeat (300) begin
            tick(1);
            if (end_match_irq === 1'b1) seen++;
        end
        check("no match", seen[15:0], 16'h0000);
        check("still counting", {15'h0, count_register > 16'h0100}, 16'h1);
        set_cmp(16'h0002, CNT_MAX, 1'b0);
        wait_irq(70000);
        tick(1);
        check("wrap set", {15'h0, wrap_flag}, 16'h1);
        wrap_flag_clear = 1'b1;
        tick(1);
        wrap_flag_clear = 1'b0;
        tick(1);
        check("wrap clear", {15'h0, wrap_flag}, 16'h0);
        end_sim();
    end
endmodule : test_timer16_one_shot_pulse
bind timer16_one_shot_pulse timer16_checker timer16_checker_inst (.clk_sys, .rst, .timer_mode_control,
    .compare_begin_write, .compare_begin_read, .soft_pulse_trigger, .count_prescale, .count_register,
    .compare_end_register, .compare_begin_register, .pulse_output_pin, .end_match_irq, .input_edge_irq,
    .input_edge_irq_flag, .wrap_flag, .pulse_busy);

/* testbench/timer16_checker.sv */
// port-level assertions for the one-shot timer
`timescale 1ns/1ps
module timer16_checker
    import timer16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input timer16_pkg::timer_ctrl_t timer_mode_control,
    input wire logic compare_begin_write,
    input wire logic compare_begin_read,
    input wire logic soft_pulse_trigger,
    input wire logic [1:0] count_prescale,
    input wire logic [15:0] count_register,
    input wire logic [15:0] compare_end_register,
    input wire logic [15:0] compare_begin_register,
    input wire logic pulse_output_pin,
    input wire logic end_match_irq,
    input wire logic input_edge_irq,
    input wire logic input_edge_irq_flag,
    input wire logic wrap_flag,
    input wire logic pulse_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic run6 = timer_mode_control.mode_select == MODE_CLEAR_ON_END;
    // exact pin timing only holds with a tick every clock and plain polarity
    wire logic plain = run6 && count_prescale == 2'h0 && timer_mode_control.output_enable
        && !timer_mode_control.output_active_low;
    property p_stop;
        timer_mode_control.mode_select == MODE_STOP |=> count_register == CNT_ZERO;
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_soft;
        soft_pulse_trigger && !timer_mode_control.external_trigger && !pulse_busy
            && timer_mode_control.mode_select != MODE_STOP |=> count_register == CNT_ZERO && pulse_busy;
    endproperty
    a_soft: assert property (p_soft) else $error("soft trigger did not restart count");
    property p_rise;
        plain && $rose(pulse_output_pin) |-> $past(count_register) == compare_begin_register;
    endproperty
    a_rise: assert property (p_rise) else $error("pulse rose off the begin match");
    property p_fall;
        plain && $fell(pulse_output_pin) |-> end_match_irq && $past(count_register) == compare_end_register;
    endproperty
    a_fall: assert property (p_fall) else $error("pulse fell off the end match");
    property p_end;
        plain && end_match_irq |-> count_register == CNT_ZERO ##1 (!end_match_irq && count_register == 16'h0001);
    endproperty
    a_end: assert property (p_end) else $error("count not running after end match");
    property p_hold;
        compare_begin_read && !compare_begin_write |=> $stable(compare_begin_register);
    endproperty
    a_hold: assert property (p_hold) else $error("begin register changed during read");
    property p_flag;
        $rose(input_edge_irq) |-> ##[0:1] input_edge_irq_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("edge flag missing");
    property p_wrap;
        run6 && compare_end_register == CNT_MAX && count_register == CNT_MAX ##1 count_register == CNT_ZERO
            |-> ##[0:1] wrap_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag not set");
    c_pulse: cover property (end_match_irq && pulse_output_pin == 1'b0);
    c_wrap: cover property ($rose(wrap_flag));
    c_edge: cover property (input_edge_irq);
endmodule : timer16_checker

/* testbench/trigger_source.sv */
// far-side model: drives the trigger pin and measures output pulses
`timescale 1ns/1ps
module trigger_source (
    input wire logic clk_sys,
    input wire logic pulse_output_pin,
    output logic trigger_input_pin
);
    int run = 0;
    int width_seen = 0;
    initial trigger_input_pin = 1'b0;
    // high time of the last finished pulse, in system clocks
    always @(posedge clk_sys) begin
        run <= pulse_output_pin ? run + 1 : 0;
        if (!pulse_output_pin && run != 0) width_seen <= run;
    end
    task automatic drive(input logic level);
        trigger_input_pin = level;
    endtask : drive
endmodule : trigger_source
